// ### verilog/ppm_pin_mux.sv
// Purpose: Function multiplexer for six port pins: gpio, pwm, comparator,
//          external interrupts, wake-up and digital input gating
// Assumes: Generator and comparator inputs are on clock_i; pin inputs are not
// Notes: Pa5 stays open drain for every function, pwm included
// Function
// (RQ1) Porta bit5 never drives high; open drain.
// (RQ2) Porta bit5 wake blocked when input disabled.
// (RQ3) Porta bits 3,4: disable gates buffer, wake.
// (RQ4) Portb bits 6,7: disable gates buffer, wake.
// (RQ5) Porta bit0 wake blocked when input disabled.
// (RQ6) Porta bit4 selectable as interrupt line one.
// (RQ7) Porta bit0 selectable as interrupt line zero.
// (RQ8) Interrupt edge: rising, falling or both.
// (RQ9) Other pins push-pull, software pulls per pin.
// (RQ10) Route pwm generators and timer pwm.
// (RQ11) Porta bit0 can drive comparator result.
// (RQ12) Fixed output priority, one driver per pin.
`timescale 1ns/100ps

module ppm_pin_mux
   import ppm_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Pad side
   input wire logic [NUM_PINS-1:0] pin_in_i,
   output ppm_drive_type [NUM_PINS-1:0] pin_drv_o,
   // Per-pin software configuration
   input wire ppm_cfg_type [NUM_PINS-1:0] pin_cfg_i,
   input wire logic reset_fn_en_i,
   // Alternate output sources
   input wire logic [NUM_PWMG-1:0] pwm_gen_i,
   input wire logic [NUM_TMR-1:0] timer_pwm_i,
   input wire logic comparator_i,
   // External interrupt control
   input wire logic irq0_en_i,
   input wire logic irq1_alt_sel_i,
   input wire ppm_edge_type irq0_edge_i,
   input wire ppm_edge_type irq1_edge_i,
   // Results to the core
   output logic [NUM_PINS-1:0] dig_in_o,
   output logic wake_o,
   output logic [1:0] irq_o,
   output logic ext_reset_req_o
);

   // Highest-priority enabled function that this pin actually offers
   function automatic ppm_sel_type pick_sel(input ppm_cfg_type c, input logic hc,
                                            input logic hp, input logic ht);
      if (c.cmp_en && hc) begin
         return SEL_CMP;
      end else if (c.pwmg_en && hp) begin
         return SEL_PWMG;
      end else if (c.tmr_en && ht) begin
         return SEL_TMR;
      end
      return SEL_GPIO;
   endfunction : pick_sel

   // Illegal edge codes never fire
   function automatic logic edge_hit(input ppm_edge_type m, input logic cur,
                                     input logic prev);
      unique case (m)
         EDGE_RISE: return cur && !prev;
         EDGE_FALL: return !cur && prev;
         EDGE_BOTH: return cur != prev;
         default: return 1'b0;
      endcase
   endfunction : edge_hit

   logic [NUM_PINS-1:0] meta_r;
   logic [NUM_PINS-1:0] sync_r;
   logic [NUM_PINS-1:0] sync_prev_r;
   logic [NUM_PINS-1:0] dig_prev_r;
   logic [NUM_PINS-1:0] dier_w;
   logic [NUM_PINS-1:0] toggle_w;
   logic [NUM_PINS-1:0] dig_in_nxt;
   logic wake_nxt;
   logic [1:0] irq_nxt;
   ppm_drive_type [NUM_PINS-1:0] drv_all_w;

   // Two-stage synchroniser; meta_r feeds sync_r only
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= SYNC_RST;
         sync_r <= SYNC_RST;
         sync_prev_r <= SYNC_RST;
      end else begin
         meta_r <= pin_in_i;
         sync_r <= meta_r;
         sync_prev_r <= sync_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         ppm_sel_type sel_w;
         ppm_drive_type drv_nxt;
         logic src_w;
         logic active_w;

         assign dier_w[gi] = pin_cfg_i[gi].dig_in_en;

         always_comb begin
            sel_w = pick_sel(pin_cfg_i[gi], HAS_CMP[gi], HAS_PWMG[gi], HAS_TMR[gi]); // [RQ12]
            src_w = pin_cfg_i[gi].out_val;
            active_w = pin_cfg_i[gi].dir_out;
            unique case (sel_w)
               SEL_CMP: begin
                  src_w = comparator_i; // [RQ11]
                  active_w = 1'b1;
               end
               SEL_PWMG: begin
                  src_w = pwm_gen_i[PWMG_SRC[gi]]; // [RQ10]
                  active_w = 1'b1;
               end
               SEL_TMR: begin
                  src_w = timer_pwm_i[TMR_SRC[gi]]; // [RQ10]
                  active_w = 1'b1;
               end
               SEL_GPIO: begin
                  src_w = pin_cfg_i[gi].out_val;
                  active_w = pin_cfg_i[gi].dir_out;
               end
            endcase
            // Reset input function takes the pin away from every driver
            if (gi == PIN_PA5 && reset_fn_en_i) begin
               active_w = 1'b0;
            end
            // Pull-down yields when both pulls are asked for
            drv_nxt.pull_up = pin_cfg_i[gi].pull_up; // [RQ9]
            drv_nxt.pull_dn = pin_cfg_i[gi].pull_dn && !pin_cfg_i[gi].pull_up; // [RQ9]
            if (OPEN_DRAIN[gi]) begin
               drv_nxt.out = 1'b0; // [RQ1]
               drv_nxt.oe = active_w && !src_w; // [RQ1]
            end else begin
               drv_nxt.out = src_w; // [RQ9]
               drv_nxt.oe = active_w; // [RQ9]
            end
         end

         assign drv_all_w[gi] = drv_nxt;

         // Analog-capable pins lose the buffer; the others only lose wake
         assign dig_in_nxt[gi] = sync_r[gi] && (dier_w[gi] || !GATE_INPUT[gi]); // [RQ3] [RQ4]
         assign toggle_w[gi] = sync_r[gi] ^ sync_prev_r[gi];
      end
   endgenerate

   // One register for all pads keeps a single process on the port
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_drv_o <= '0;
      end else begin
         pin_drv_o <= drv_all_w;
      end
   end

   // Wake on any toggle of an input-enabled pin
   assign wake_nxt = |(toggle_w & dier_w); // [RQ2] [RQ3] [RQ4] [RQ5]

   always_comb begin
      irq_nxt[0] = irq0_en_i
         && edge_hit(irq0_edge_i, dig_in_o[PIN_PA0], dig_prev_r[PIN_PA0]); // [RQ7] [RQ8]
      irq_nxt[1] = irq1_alt_sel_i
         && edge_hit(irq1_edge_i, dig_in_o[PIN_PA4], dig_prev_r[PIN_PA4]); // [RQ6] [RQ8]
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         dig_in_o <= SYNC_RST;
         dig_prev_r <= SYNC_RST;
      end else begin
         dig_in_o <= dig_in_nxt;
         dig_prev_r <= dig_in_o;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= wake_nxt;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= IRQ_RST;
      end else begin
         irq_o <= irq_nxt;
      end
   end

   // Reset pin is active low at the pad
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ext_reset_req_o <= 1'b0;
      end else begin
         ext_reset_req_o <= reset_fn_en_i && !sync_r[PIN_PA5];
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   chk_pa5_never_high: assert property ( // [RQ1]
      !(pin_drv_o[PIN_PA5].oe && pin_drv_o[PIN_PA5].out))
      else $error("porta bit5 drove a high level");

   chk_pa5_wake_off: assert property ( // [RQ2]
      (toggle_w == 6'h08 && !dier_w[PIN_PA5]) |=> !wake_o)
      else $error("porta bit5 woke while input disabled");

   chk_pa0_wake_off: assert property ( // [RQ5]
      (toggle_w == 6'h01 && !dier_w[PIN_PA0]) |=> !wake_o)
      else $error("porta bit0 woke while input disabled");

   chk_wake_has_cause: assert property ( // [RQ3]
      wake_o |-> $past(|(toggle_w & dier_w)))
      else $error("wake without an enabled toggle");

   chk_pa3_buffer_off: assert property ( // [RQ3]
      !dier_w[PIN_PA3] |=> !dig_in_o[PIN_PA3])
      else $error("porta bit3 buffer not gated");

   chk_pb7_buffer_off: assert property ( // [RQ4]
      !dier_w[PIN_PB7] ##1 !dier_w[PIN_PB7] |=> !dig_in_o[PIN_PB7])
      else $error("portb bit7 buffer not gated");

   chk_irq1_rise: assert property ( // [RQ6]
      (irq1_alt_sel_i && irq1_edge_i == EDGE_RISE && dig_in_o[PIN_PA4]
         && !dig_prev_r[PIN_PA4]) |=> irq_o[1])
      else $error("line one missed a rising edge");

   chk_irq0_fall: assert property ( // [RQ7]
      (irq0_en_i && irq0_edge_i == EDGE_FALL && !dig_in_o[PIN_PA0]
         && dig_prev_r[PIN_PA0]) |=> irq_o[0])
      else $error("line zero missed a falling edge");

   chk_irq0_edge_kind: assert property ( // [RQ8]
      irq_o[0] |-> $past(irq0_en_i) && $past(dig_in_o[PIN_PA0]) != $past(dig_prev_r[PIN_PA0]))
      else $error("line zero fired without an edge");

   chk_pb6_push_pull: assert property ( // [RQ9]
      (pin_cfg_i[PIN_PB6].dir_out && !pin_cfg_i[PIN_PB6].pwmg_en && !pin_cfg_i[PIN_PB6].tmr_en)
         |=> pin_drv_o[PIN_PB6].oe && pin_drv_o[PIN_PB6].out == $past(pin_cfg_i[PIN_PB6].out_val))
      else $error("portb bit6 gpio drive wrong");

   chk_pa4_pwm_route: assert property ( // [RQ10]
      pin_cfg_i[PIN_PA4].pwmg_en |=> pin_drv_o[PIN_PA4].oe
         && pin_drv_o[PIN_PA4].out == $past(pwm_gen_i[1]))
      else $error("porta bit4 pwm not routed");

   chk_pa0_cmp_wins: assert property ( // [RQ11]
      (pin_cfg_i[PIN_PA0].cmp_en && pin_cfg_i[PIN_PA0].pwmg_en)
         |=> pin_drv_o[PIN_PA0].out == $past(comparator_i) && pin_drv_o[PIN_PA0].oe)
      else $error("comparator did not own porta bit0");

   chk_pa3_pwm_over_tmr: assert property ( // [RQ12]
      (pin_cfg_i[PIN_PA3].pwmg_en && pin_cfg_i[PIN_PA3].tmr_en)
         |=> pin_drv_o[PIN_PA3].out == $past(pwm_gen_i[2]))
      else $error("porta bit3 priority wrong");

   // Three gated cycles clear both the current and the previous level
   chk_pa4_irq_gated: assert property ( // [RQ3]
      (!dier_w[PIN_PA4]) [*3] |=> !irq_o[1])
      else $error("line one fired from a gated pin");

   chk_pb6_wake_off: assert property ( // [RQ4]
      (toggle_w == 6'h10 && !dier_w[PIN_PB6]) |=> !wake_o)
      else $error("portb bit6 woke while input disabled");

   chk_pull_one_side: assert property ( // [RQ9]
      pin_cfg_i[PIN_PB6].pull_up |=> pin_drv_o[PIN_PB6].pull_up
         && !pin_drv_o[PIN_PB6].pull_dn)
      else $error("portb bit6 pulls both ways");

   chk_pb7_tmr_route: assert property ( // [RQ10]
      (pin_cfg_i[PIN_PB7].tmr_en && !pin_cfg_i[PIN_PB7].pwmg_en) |=> pin_drv_o[PIN_PB7].oe
         && pin_drv_o[PIN_PB7].out == $past(timer_pwm_i[1]))
      else $error("portb bit7 timer pwm not routed");

   chk_pa3_tmr_route: assert property ( // [RQ10]
      (pin_cfg_i[PIN_PA3].tmr_en && !pin_cfg_i[PIN_PA3].pwmg_en) |=> pin_drv_o[PIN_PA3].oe
         && pin_drv_o[PIN_PA3].out == $past(timer_pwm_i[0]))
      else $error("porta bit3 timer pwm not routed");

   chk_irq1_both: assert property ( // [RQ8]
      (irq1_alt_sel_i && irq1_edge_i == EDGE_BOTH
         && dig_in_o[PIN_PA4] != dig_prev_r[PIN_PA4]) |=> irq_o[1])
      else $error("line one missed an edge");

   chk_irq1_off: assert property ( // [RQ6]
      !irq1_alt_sel_i |=> !irq_o[1])
      else $error("line one fired while not selected");

   chk_irq0_off: assert property ( // [RQ7]
      !irq0_en_i |=> !irq_o[0])
      else $error("line zero fired while not selected");

endmodule : ppm_pin_mux

// ### verilog/ppm_pkg.sv
// Purpose: Shared constants and types for the port pin function multiplexer
// Assumes: Six pins, indexed 0..5 as porta bits 0,3,4,5 then portb bits 6,7
// Notes: Per-pin capability masks shape the generate loop in the mux
package ppm_pkg;

   localparam int unsigned NUM_PINS = 6;
   localparam int unsigned NUM_PWMG = 3;
   localparam int unsigned NUM_TMR = 2;

   // Pin indices
   localparam int unsigned PIN_PA0 = 0;
   localparam int unsigned PIN_PA3 = 1;
   localparam int unsigned PIN_PA4 = 2;
   localparam int unsigned PIN_PA5 = 3;
   localparam int unsigned PIN_PB6 = 4;
   localparam int unsigned PIN_PB7 = 5;

   // Capability masks, one bit per pin index
   localparam logic [NUM_PINS-1:0] HAS_PWMG = 6'h3F;
   localparam logic [NUM_PINS-1:0] HAS_TMR = 6'h32;
   localparam logic [NUM_PINS-1:0] HAS_CMP = 6'h01;
   localparam logic [NUM_PINS-1:0] OPEN_DRAIN = 6'h08;
   localparam logic [NUM_PINS-1:0] GATE_INPUT = 6'h36;

   // Which generator feeds each pin: pwm gen 0..2, timer 0 = two, 1 = three
   localparam int unsigned PWMG_SRC [NUM_PINS] = '{0, 2, 1, 2, 1, 1};
   localparam int unsigned TMR_SRC [NUM_PINS] = '{0, 0, 0, 0, 1, 1};

   // Reset values
   localparam logic [NUM_PINS-1:0] SYNC_RST = 6'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;

   typedef enum logic [2:0] {
      EDGE_RISE = 3'h1,
      EDGE_FALL = 3'h2,
      EDGE_BOTH = 3'h4
   } ppm_edge_type;

   typedef enum logic [3:0] {
      SEL_GPIO = 4'h1,
      SEL_TMR = 4'h2,
      SEL_PWMG = 4'h4,
      SEL_CMP = 4'h8
   } ppm_sel_type;

   typedef struct packed {
      logic out_val;
      logic dir_out;
      logic pull_up;
      logic pull_dn;
      logic dig_in_en;
      logic pwmg_en;
      logic tmr_en;
      logic cmp_en;
   } ppm_cfg_type;

   typedef struct packed {
      logic out;
      logic oe;
      logic pull_up;
      logic pull_dn;
   } ppm_drive_type;

endpackage : ppm_pkg

// ### verification/ppm_pad_model.sv
// Purpose: Board side of the six pads: drivers, pulls, external levels
// Assumes: An external source loses to the mux driving the pad
// Notes: An undriven, unpulled pad toggles every cycle so it never reads as a stable level
`timescale 1ns/100ps
module ppm_pad_model
   import ppm_pkg::*;
(
   // Clock
   input wire logic clock_i,
   // Pads
   input wire ppm_drive_type [NUM_PINS-1:0] pin_drv_i,
   input wire logic [NUM_PINS-1:0] ext_en_i,
   input wire logic [NUM_PINS-1:0] ext_val_i,
   output logic [NUM_PINS-1:0] pad_o
);
   logic float_r = 1'b0;
   always_ff @(posedge clock_i) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (pin_drv_i[i].oe)
            pad_o[i] = pin_drv_i[i].out;
         else if (ext_en_i[i])
            pad_o[i] = ext_val_i[i];
         else if (pin_drv_i[i].pull_up)
            pad_o[i] = 1'b1;
         else if (pin_drv_i[i].pull_dn)
            pad_o[i] = 1'b0;
         else
            pad_o[i] = float_r;
      end
   end
endmodule : ppm_pad_model

// ### verification/testbench.sv
// Purpose: Self-checking bench for the pin function multiplexer
// Assumes: Sources start at comparator 1, pwm gens 3'h4, timer pwm 2'h2
// Notes: Pulse counters sample on the falling edge, clear of the launch edge
`timescale 1ns/100ps
module testbench
   import ppm_pkg::*;
;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   ppm_cfg_type [NUM_PINS-1:0] cfg;
   ppm_drive_type [NUM_PINS-1:0] drv;
   logic [NUM_PINS-1:0] pad;
   logic [NUM_PINS-1:0] ext_en;
   logic [NUM_PINS-1:0] ext_val;
   logic [NUM_PINS-1:0] dig_in;
   logic irq0_en;
   logic irq1_sel;
   logic wake;
   logic [1:0] irq;
   ppm_edge_type edge0;
   ppm_edge_type edge1;
   logic cmp_src;
   logic [NUM_PWMG-1:0] pwm_src;
   logic [NUM_TMR-1:0] tmr_src;
   logic reset_fn;
   logic reset_req;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   int wakes = 0;
   int irqs0 = 0;
   int irqs1 = 0;

   always #5 clock_i = ~clock_i;

   ppm_pin_mux u_dut (.clock_i(clock_i), .rst_i(rst_i), .pin_in_i(pad), .pin_drv_o(drv),
      .pin_cfg_i(cfg), .reset_fn_en_i(reset_fn), .pwm_gen_i(pwm_src), .timer_pwm_i(tmr_src),
      .comparator_i(cmp_src), .irq0_en_i(irq0_en), .irq1_alt_sel_i(irq1_sel),
      .irq0_edge_i(edge0), .irq1_edge_i(edge1), .dig_in_o(dig_in), .wake_o(wake),
      .irq_o(irq), .ext_reset_req_o(reset_req));

   ppm_pad_model u_pads (.clock_i(clock_i), .pin_drv_i(drv), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_o(pad));

   always @(negedge clock_i) begin
      cycles++;
      if (wake === 1'b1)
         wakes++;
      if (irq[0] === 1'b1)
         irqs0++;
      if (irq[1] === 1'b1)
         irqs1++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wait_n(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : wait_n

   // Out bit is only judged while the pin drives
   task automatic drive_case(input int p, input logic [7:0] c, input logic [3:0] exp);
      ppm_cfg_type [NUM_PINS-1:0] c_all;
      logic [3:0] m;
      c_all = {NUM_PINS{8'h10}};
      c_all[p] = c;
      m = exp[2] ? 4'hF : 4'h7;
      @(posedge clock_i);
      cfg <= c_all;
      wait_n(3);
      check("pin drive", {4'h0, exp & m}, {4'h0, 4'(drv[p]) & m});
   endtask : drive_case

   // Second pass inverts every source so no route can pass by a stuck level
   task automatic route_cases();
      for (int f = 0; f < 2; f++) begin
         @(posedge clock_i);
         cmp_src <= f[0] ? 1'b0 : 1'b1;
         pwm_src <= f[0] ? 3'h3 : 3'h4;
         tmr_src <= f[0] ? 2'h1 : 2'h2;
         drive_case(PIN_PA5, 8'h44, f[0] ? 4'h4 : 4'h0);
         drive_case(PIN_PA0, 8'h45, f[0] ? 4'h4 : 4'hC);
         drive_case(PIN_PA0, 8'hC4, f[0] ? 4'hC : 4'h4);
         drive_case(PIN_PA4, 8'hC4, f[0] ? 4'hC : 4'h4);
         drive_case(PIN_PB7, 8'h42, f[0] ? 4'h4 : 4'hC);
         drive_case(PIN_PA3, 8'hC2, f[0] ? 4'hC : 4'h4);
         drive_case(PIN_PA3, 8'h06, f[0] ? 4'h4 : 4'hC);
      end
   endtask : route_cases

   task automatic reset_fn_case();
      @(posedge clock_i);
      reset_fn <= 1'b1;
      drive_case(PIN_PA5, 8'h40, 4'h0);
      check("reset request", 8'h1, {7'h0, reset_req});
      @(posedge clock_i);
      ext_val[PIN_PA5] <= 1'b1;
      wait_n(5);
      check("reset request", 8'h0, {7'h0, reset_req});
      @(posedge clock_i);
      reset_fn <= 1'b0;
   endtask : reset_fn_case

   task automatic pulse_pad(input int p, input logic exp_dig);
      @(posedge clock_i);
      ext_val[p] <= 1'b1;
      wait_n(5);
      check("digital input", {7'h0, exp_dig}, {7'h0, dig_in[p]});
      @(posedge clock_i);
      ext_val[p] <= 1'b0;
      wait_n(6);
   endtask : pulse_pad

   task automatic irq_edges();
      ppm_edge_type e [3] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
      for (int k = 0; k < 3; k++) begin
         @(posedge clock_i);
         edge0 <= e[k];
         wait_n(4);
         irqs0 = 0;
         pulse_pad(PIN_PA0, 1'b1);
         check("irq0 pulses", (k == 2) ? 8'h2 : 8'h1, 8'(irqs0));
      end
   endtask : irq_edges

   task automatic gate_wake();
      for (int d = 0; d < 2; d++) begin
         @(posedge clock_i);
         cfg <= {NUM_PINS{d[0] ? 8'h18 : 8'h10}};
         wait_n(4);
         for (int p = 0; p < NUM_PINS; p++) begin
            wakes = 0;
            pulse_pad(p, d[0] | ~GATE_INPUT[p]);
            check("wake pulses", d[0] ? 8'h2 : 8'h0, 8'(wakes));
         end
      end
   endtask : gate_wake

   task automatic irq_alt();
      for (int s = 0; s < 3; s++) begin
         @(posedge clock_i);
         irq1_sel <= (s != 0);
         edge1 <= (s == 2) ? EDGE_RISE : EDGE_BOTH;
         wait_n(4);
         irqs1 = 0;
         pulse_pad(PIN_PA4, 1'b1);
         check("irq1 pulses", (s == 0) ? 8'h0 : ((s == 1) ? 8'h2 : 8'h1),
            8'(irqs1));
      end
   endtask : irq_alt

   initial begin
      cfg = {NUM_PINS{8'h10}};
      ext_en = '0;
      ext_val = '0;
      irq0_en = 1'b0;
      irq1_sel = 1'b0;
      edge0 = EDGE_RISE;
      edge1 = EDGE_BOTH;
      cmp_src = 1'b1;
      pwm_src = 3'h4;
      tmr_src = 2'h2;
      reset_fn = 1'b0;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      wait_n(4);
      drive_case(PIN_PB6, 8'hC0, 4'hC);
      drive_case(PIN_PB6, 8'h30, 4'h2);
      drive_case(PIN_PA5, 8'hC0, 4'h0);
      drive_case(PIN_PA5, 8'h40, 4'h4);
      route_cases();
      @(posedge clock_i);
      ext_en <= '1;
      cfg <= {NUM_PINS{8'h18}};
      irq0_en <= 1'b1;
      wait_n(6);
      irq_edges();
      gate_wake();
      irq_alt();
      reset_fn_case();
      report_and_stop();
   end
endmodule : testbench
